// ---- common/fps_map.svh ----
// register offsets, field positions, reset values and timing counts
`ifndef FPS_MAP_SVH
`define FPS_MAP_SVH

// software register offsets (byte addresses)
`define FPS_OFF_CTRL    5'h00
`define FPS_OFF_ADDR    5'h04
`define FPS_OFF_WDATA   5'h08
`define FPS_OFF_RDATA   5'h0c
`define FPS_OFF_CFG     5'h10
`define FPS_OFF_STATUS  5'h14
`define FPS_OFF_ISTAT   5'h18
`define FPS_OFF_IMASK   5'h1c

// control register fields
`define FPS_CTRL_GO     0
`define FPS_CTRL_CMD_LO 1
`define FPS_CTRL_CMD_HI 3

// command codes
`define FPS_CMD_WRITE      3'h0
`define FPS_CMD_WRITE_LAST 3'h1
`define FPS_CMD_READ       3'h2
`define FPS_CMD_POLL_TOG   3'h3
`define FPS_CMD_POLL_DATA  3'h4
`define FPS_CMD_PROTECT    3'h5

// configuration register fields
`define FPS_CFG_CE_STROBE  0
`define FPS_CFG_TOG_CE     1
`define FPS_CFG_UNPROTECT  2
`define FPS_CFG_TEMP_UNPR  3
`define FPS_CFG_W          4
`define FPS_CFG_RESET      4'h0

// event bits of interrupt status and mask
`define FPS_EV_DONE     0
`define FPS_EV_TIMEOUT  1
`define FPS_EV_SUSPEND  2
`define FPS_EV_W        3

// status bit positions inside the flash data word
`define FPS_DQ_SUSP_TOG 2
`define FPS_DQ_TOGGLE   6
`define FPS_DQ_POLL     7

// protect-select address bit positions
`define FPS_A_PROT_SEL  6
`define FPS_A_BIT_ONE   1
`define FPS_A_BIT_ZERO  0

// timing in printed units and derived cycle counts
`define FPS_CLK_NS      50
`define FPS_T_BUSY_NS   90
`define FPS_T_ACC_NS    120
`define FPS_T_RSP_US    4
`define FPS_BUSY_CYC ((`FPS_T_BUSY_NS + `FPS_CLK_NS - 1) / `FPS_CLK_NS)
`define FPS_ACC_CYC  ((`FPS_T_ACC_NS + `FPS_CLK_NS - 1) / `FPS_CLK_NS)
`define FPS_RSP_CYC  ((`FPS_T_RSP_US * 1000 + `FPS_CLK_NS - 1) / `FPS_CLK_NS)
`define FPS_TMR_W       8

`endif

// ---- common/fps_pkg.sv ----
// types shared by the flash host controller
package fps_pkg;

  // controller sequencer states
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_START,
    ST_WR_STB,
    ST_WR_HOLD,
    ST_WR_END,
    ST_BUSY_DLY,
    ST_BUSY_WAIT,
    ST_RD_WAIT,
    ST_RD_END
  } fps_state_e;

endpackage

// ---- src/fps_tmr.sv ----
// down counter used for pin phase and wait timing
`timescale 1ns/10ps
`include "fps_map.svh"

module fps_tmr #(
  parameter int W = `FPS_TMR_W
) (
  // clock and reset
  input  logic         sys_clk,
  input  logic         rst,
  // load and status
  input  logic         load,
  input  logic [W-1:0] val,
  output logic         done
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } fps_tmr_s;

  fps_tmr_s s_r;
  fps_tmr_s s_nxt;

  // load or count toward zero
  always_comb
  begin
    s_nxt = s_r;
    if (load)
    begin
      s_nxt.cnt = val;
    end
    else if (s_r.cnt != '0)
    begin
      s_nxt.cnt = s_r.cnt - W'(1);
    end
  end

  // state register
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // expired when zero
  assign done = (s_r.cnt == '0);

endmodule

// ---- src/fps_host_ctrl.sv ----
// host controller that writes, programs and polls a parallel flash
`timescale 1ns/10ps
`include "fps_map.svh"

// Function
// - wait 90 ns before sampling ready/busy
// - next read may start right at ready
// - status reads toggle via chip or output enable
// - protect: select line low, bit1 high, bit0 low
// - unprotect: select line high, bit1 high, bit0 low
// - elevated reset held 4 us before writes
module fps_host_ctrl #(
  parameter int          ADDR_W   = 19,
  parameter int          DATA_W   = 16,
  parameter logic [15:0] POLL_MAX = 16'hffff
) (
  // clock and reset
  input  logic              sys_clk,
  input  logic              rst,
  // software register port
  input  logic [4:0]        reg_addr,
  input  logic [31:0]       reg_wdata,
  input  logic              reg_wr,
  input  logic              reg_rd,
  output logic [31:0]       reg_rdata,
  output logic              irq,
  // flash pins
  output logic [ADDR_W-1:0] flash_addr,
  output logic [DATA_W-1:0] flash_dq_out,
  output logic              flash_dq_oe,
  input  logic [DATA_W-1:0] flash_dq_in,
  output logic              flash_ce_n,
  output logic              flash_oe_n,
  output logic              flash_we_n,
  output logic              flash_reset_hv,
  input  logic              ready_busy_n
);

  typedef struct packed {
    fps_pkg::fps_state_e     state;
    logic [2:0]              cmd;
    logic [ADDR_W-1:0]       addr;
    logic [DATA_W-1:0]       wdata;
    logic [DATA_W-1:0]       rdat;
    logic [DATA_W-1:0]       prev;
    logic                    have_prev;
    logic                    final_rd;
    logic [15:0]             polls;
    logic [`FPS_CFG_W-1:0]   cfg;
    logic [`FPS_EV_W-1:0]    istat;
    logic [`FPS_EV_W-1:0]    imask;
    logic                    irq;
    logic [31:0]             rd_data;
    logic [ADDR_W-1:0]       pin_addr;
    logic                    dq_oe;
    logic                    ce_n;
    logic                    oe_n;
    logic                    we_n;
  } fps_ctrl_s;

  fps_ctrl_s s_r;
  fps_ctrl_s s_nxt;

  logic                  tmr_load;
  logic [`FPS_TMR_W-1:0] tmr_val;
  logic                  tmr_done;
  logic                  rsp_load;
  logic                  rsp_done;
  logic                  rsp_ok;
  logic                  busy;
  logic                  is_write;
  logic [ADDR_W-1:0]     prot_addr;

  // pin phase, busy delay timer
  fps_tmr #(.W(`FPS_TMR_W)) u_phase_tmr (
    .sys_clk (sys_clk),
    .rst     (rst),
    .load    (tmr_load),
    .val     (tmr_val),
    .done    (tmr_done)
  );

  // elevated reset setup timer
  fps_tmr #(.W(`FPS_TMR_W)) u_rsp_tmr (
    .sys_clk (sys_clk),
    .rst     (rst),
    .load    (rsp_load),
    .val     (`FPS_TMR_W'(`FPS_RSP_CYC)),
    .done    (rsp_done)
  );

  // derived conditions
  assign busy     = (s_r.state != fps_pkg::ST_IDLE);
  assign is_write = (s_r.cmd == `FPS_CMD_WRITE) ||
                    (s_r.cmd == `FPS_CMD_WRITE_LAST) ||
                    (s_r.cmd == `FPS_CMD_PROTECT);
  // temp unprotect: writes wait out the setup time
  assign rsp_ok   = !s_r.cfg[`FPS_CFG_TEMP_UNPR] || rsp_done;
  // timer restarts when elevated reset is switched on
  assign rsp_load = reg_wr && (reg_addr == `FPS_OFF_CFG) &&
                    reg_wdata[`FPS_CFG_TEMP_UNPR] &&
                    !s_r.cfg[`FPS_CFG_TEMP_UNPR];

  // protect or unprotect address selection
  always_comb
  begin
    prot_addr = s_r.addr;
    prot_addr[`FPS_A_PROT_SEL] = s_r.cfg[`FPS_CFG_UNPROTECT];
    prot_addr[`FPS_A_BIT_ONE]  = 1'b1;
    prot_addr[`FPS_A_BIT_ZERO] = 1'b0;
  end

  // register port, sequencer and events
  always_comb
  begin
    s_nxt    = s_r;
    tmr_load = 1'b0;
    tmr_val  = '0;
    s_nxt.rd_data = '0;

    // register writes
    if (reg_wr)
    begin
      case (reg_addr)
        `FPS_OFF_CTRL:
        begin
          if (reg_wdata[`FPS_CTRL_GO] && !busy)
          begin
            s_nxt.cmd   = reg_wdata[`FPS_CTRL_CMD_HI:`FPS_CTRL_CMD_LO];
            s_nxt.state = fps_pkg::ST_START;
          end
        end
        `FPS_OFF_ADDR:  s_nxt.addr  = reg_wdata[ADDR_W-1:0];
        `FPS_OFF_WDATA: s_nxt.wdata = reg_wdata[DATA_W-1:0];
        `FPS_OFF_CFG:   s_nxt.cfg   = reg_wdata[`FPS_CFG_W-1:0];
        `FPS_OFF_IMASK: s_nxt.imask = reg_wdata[`FPS_EV_W-1:0];
        default:        s_nxt.cfg   = s_r.cfg;
      endcase
    end

    // register reads, data in the next cycle
    if (reg_rd)
    begin
      case (reg_addr)
        `FPS_OFF_CTRL:   s_nxt.rd_data = {28'h0, s_r.cmd, busy};
        `FPS_OFF_ADDR:   s_nxt.rd_data = 32'(s_r.addr);
        `FPS_OFF_WDATA:  s_nxt.rd_data = 32'(s_r.wdata);
        `FPS_OFF_RDATA:  s_nxt.rd_data = 32'(s_r.rdat);
        `FPS_OFF_CFG:    s_nxt.rd_data = 32'(s_r.cfg);
        `FPS_OFF_STATUS:
          s_nxt.rd_data = {29'h0, rsp_ok, ready_busy_n, busy};
        `FPS_OFF_ISTAT:
        begin
          s_nxt.rd_data = 32'(s_r.istat);
          s_nxt.istat   = '0;   // read clears, events below win
        end
        `FPS_OFF_IMASK:  s_nxt.rd_data = 32'(s_r.imask);
        default:         s_nxt.rd_data = '0;
      endcase
    end

    // sequencer
    case (s_r.state)
      fps_pkg::ST_IDLE:
      begin
        s_nxt.ce_n  = 1'b1;
        s_nxt.oe_n  = 1'b1;
        s_nxt.we_n  = 1'b1;
        s_nxt.dq_oe = 1'b0;
      end
      fps_pkg::ST_START:
      begin
        if (is_write)
        begin
          if (rsp_ok)
          begin
            s_nxt.pin_addr = (s_r.cmd == `FPS_CMD_PROTECT) ?
                             prot_addr : s_r.addr;
            s_nxt.dq_oe    = 1'b1;
            s_nxt.oe_n     = 1'b1;
            // setup phase holds the non-strobing line low
            if (s_r.cfg[`FPS_CFG_CE_STROBE])
            begin
              s_nxt.we_n = 1'b0;
            end
            else
            begin
              s_nxt.ce_n = 1'b0;
            end
            s_nxt.state = fps_pkg::ST_WR_STB;
          end
        end
        else
        begin
          // any address serves for toggle polling
          s_nxt.pin_addr  = s_r.addr;
          s_nxt.ce_n      = 1'b0;
          s_nxt.oe_n      = 1'b0;
          s_nxt.have_prev = 1'b0;
          s_nxt.final_rd  = (s_r.cmd == `FPS_CMD_READ);
          s_nxt.polls     = '0;
          tmr_load        = 1'b1;
          tmr_val         = `FPS_TMR_W'(`FPS_ACC_CYC);
          s_nxt.state     = fps_pkg::ST_RD_WAIT;
        end
      end
      fps_pkg::ST_WR_STB:
      begin
        // one strobe cycle on the chosen line
        if (s_r.cfg[`FPS_CFG_CE_STROBE])
        begin
          s_nxt.ce_n = 1'b0;
        end
        else
        begin
          s_nxt.we_n = 1'b0;
        end
        s_nxt.state = fps_pkg::ST_WR_HOLD;
      end
      fps_pkg::ST_WR_HOLD:
      begin
        // rising strobe latches data, data still driven
        s_nxt.ce_n  = 1'b1;
        s_nxt.we_n  = 1'b1;
        s_nxt.state = fps_pkg::ST_WR_END;
      end
      fps_pkg::ST_WR_END:
      begin
        s_nxt.dq_oe = 1'b0;
        if (s_r.cmd == `FPS_CMD_WRITE_LAST)
        begin
          tmr_load    = 1'b1;
          tmr_val     = `FPS_TMR_W'(`FPS_BUSY_CYC);
          s_nxt.state = fps_pkg::ST_BUSY_DLY;
        end
        else
        begin
          s_nxt.state = fps_pkg::ST_IDLE;
          s_nxt.istat[`FPS_EV_DONE] = 1'b1;
        end
      end
      fps_pkg::ST_BUSY_DLY:
      begin
        // ready/busy not trusted until the delay ran out
        if (tmr_done)
        begin
          s_nxt.state = fps_pkg::ST_BUSY_WAIT;
        end
      end
      fps_pkg::ST_BUSY_WAIT:
      begin
        // ready ends the command, next read may follow at once
        if (ready_busy_n)
        begin
          s_nxt.state = fps_pkg::ST_IDLE;
          s_nxt.istat[`FPS_EV_DONE] = 1'b1;
        end
      end
      fps_pkg::ST_RD_WAIT:
      begin
        if (tmr_done)
        begin
          s_nxt.rdat      = flash_dq_in;
          s_nxt.prev      = flash_dq_in;
          s_nxt.have_prev = 1'b1;
          s_nxt.polls     = s_r.polls + 16'h0001;
          if (s_r.final_rd)
          begin
            // true array data after the operation finished
            s_nxt.ce_n  = 1'b1;
            s_nxt.oe_n  = 1'b1;
            s_nxt.state = fps_pkg::ST_IDLE;
            s_nxt.istat[`FPS_EV_DONE] = 1'b1;
          end
          else
          begin
            // release only the line used to toggle status
            if (s_r.cfg[`FPS_CFG_TOG_CE])
            begin
              s_nxt.ce_n = 1'b1;
            end
            else
            begin
              s_nxt.oe_n = 1'b1;
            end
            s_nxt.state = fps_pkg::ST_RD_END;
            if (s_r.cmd == `FPS_CMD_POLL_DATA)
            begin
              // complement seen while busy, true value at end
              if (flash_dq_in[`FPS_DQ_POLL] ==
                  s_r.wdata[`FPS_DQ_POLL])
              begin
                s_nxt.final_rd = 1'b1;
              end
            end
            else if (s_r.have_prev)
            begin
              if (flash_dq_in[`FPS_DQ_TOGGLE] ==
                  s_r.prev[`FPS_DQ_TOGGLE])
              begin
                s_nxt.final_rd = 1'b1;
              end
              // suspended sector reported when this bit moves
              if (flash_dq_in[`FPS_DQ_SUSP_TOG] !=
                  s_r.prev[`FPS_DQ_SUSP_TOG])
              begin
                s_nxt.istat[`FPS_EV_SUSPEND] = 1'b1;
              end
            end
            if (s_r.polls == POLL_MAX)
            begin
              s_nxt.ce_n  = 1'b1;
              s_nxt.oe_n  = 1'b1;
              s_nxt.state = fps_pkg::ST_IDLE;
              s_nxt.istat[`FPS_EV_TIMEOUT] = 1'b1;
            end
          end
        end
      end
      fps_pkg::ST_RD_END:
      begin
        // next status read, lowering the toggle line again
        if (s_r.cfg[`FPS_CFG_TOG_CE])
        begin
          s_nxt.ce_n = 1'b0;
        end
        else
        begin
          s_nxt.oe_n = 1'b0;
        end
        tmr_load    = 1'b1;
        tmr_val     = `FPS_TMR_W'(`FPS_ACC_CYC);
        s_nxt.state = fps_pkg::ST_RD_WAIT;
      end
      default:
      begin
        s_nxt.state = fps_pkg::ST_IDLE;
      end
    endcase

    // level interrupt from unmasked sticky bits
    s_nxt.irq = |(s_nxt.istat & s_nxt.imask);
  end

  // state register
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s_r       <= '0;
      s_r.state <= fps_pkg::ST_IDLE;
      s_r.cfg   <= `FPS_CFG_RESET;
      s_r.ce_n  <= 1'b1;
      s_r.oe_n  <= 1'b1;
      s_r.we_n  <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign reg_rdata      = s_r.rd_data;
  assign irq            = s_r.irq;
  assign flash_addr     = s_r.pin_addr;
  assign flash_dq_out   = s_r.wdata;
  assign flash_dq_oe    = s_r.dq_oe;
  assign flash_ce_n     = s_r.ce_n;
  assign flash_oe_n     = s_r.oe_n;
  assign flash_we_n     = s_r.we_n;
  assign flash_reset_hv = s_r.cfg[`FPS_CFG_TEMP_UNPR];

endmodule

// ---- dv/fps_host_ctrl_sva.sv ----
// pin-level assertions on the flash host controller
`timescale 1ns/10ps

module fps_host_ctrl_chk #(
  parameter int ADDR_W = 19,
  parameter int DATA_W = 16
) (
  // clock and reset
  input logic              sys_clk,
  input logic              rst,
  // flash pins
  input logic [ADDR_W-1:0] flash_addr,
  input logic [DATA_W-1:0] flash_dq_out,
  input logic              flash_dq_oe,
  input logic              flash_ce_n,
  input logic              flash_oe_n,
  input logic              flash_we_n,
  input logic              flash_reset_hv
);
  logic [7:0] hv_cnt_r;
  logic [7:0] hv_cnt_nxt;
  wire        wr_stb = !flash_we_n && !flash_ce_n;

  // cycles the elevated reset has stood, saturating
  always_comb
  begin
    hv_cnt_nxt = hv_cnt_r;
    if (!flash_reset_hv)
      hv_cnt_nxt = 8'h00;
    else if (hv_cnt_r != 8'hff)
      hv_cnt_nxt = hv_cnt_r + 8'h01;
  end

  always_ff @(posedge sys_clk)
    hv_cnt_r <= rst ? 8'h00 : hv_cnt_nxt;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  property p_stb_hold;
    wr_stb |-> flash_dq_oe && $stable(flash_dq_out) && $stable(flash_addr);
  endproperty
  a_stb_hold: assert property (p_stb_hold)
    else $error("address or data moved under write strobe");

  property p_stb_one;
    wr_stb |=> !wr_stb;
  endproperty
  a_stb_one: assert property (p_stb_one)
    else $error("write strobe longer than one cycle");

  property p_hv_setup;
    flash_reset_hv && wr_stb |-> hv_cnt_r >= 8'd80;
  endproperty
  a_hv_setup: assert property (p_hv_setup)
    else $error("write too soon after elevated reset");

  property p_busy_gap;
    $rose(flash_we_n) |-> flash_oe_n [*2];
  endproperty
  a_busy_gap: assert property (p_busy_gap)
    else $error("read started inside busy valid delay");

  property p_tog_oe;
    $rose(flash_oe_n) && !flash_ce_n |=> $fell(flash_oe_n);
  endproperty
  a_tog_oe: assert property (p_tog_oe)
    else $error("output enable toggle not one cycle");

  property p_tog_ce;
    $rose(flash_ce_n) && !flash_oe_n |=> $fell(flash_ce_n);
  endproperty
  a_tog_ce: assert property (p_tog_ce)
    else $error("chip enable toggle not one cycle");

  property p_no_fight;
    flash_dq_oe |-> flash_oe_n;
  endproperty
  a_no_fight: assert property (p_no_fight)
    else $error("host drives data during a read");

  property p_acc_len;
    $fell(flash_oe_n) |-> (!flash_oe_n && !flash_ce_n) [*3];
  endproperty
  a_acc_len: assert property (p_acc_len)
    else $error("read access shorter than three cycles");
endmodule

bind fps_host_ctrl fps_host_ctrl_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W))
  u_chk (.sys_clk(sys_clk), .rst(rst), .flash_addr(flash_addr),
  .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
  .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
  .flash_we_n(flash_we_n), .flash_reset_hv(flash_reset_hv));

// ---- dv/fps_flash_model.sv ----
// behavioural parallel flash on the far side of the controller
`timescale 1ns/10ps

module fps_flash_model #(
  parameter int         ADDR_W   = 19,
  parameter int         DATA_W   = 16,
  parameter int         PROG_NS  = (DATA_W == 8) ? 9000 : 11000,
  parameter int         ERASE_NS = 700000000,
  parameter logic [6:0] SUSP_SEC = 7'h05
) (
  // flash pins
  input  logic [ADDR_W-1:0] addr,
  input  logic [DATA_W-1:0] dq_wr,
  output logic [DATA_W-1:0] dq_rd,
  input  logic              ce_n,
  input  logic              oe_n,
  input  logic              we_n,
  output logic              ready_busy_n,
  // erase-suspended sector present
  input  logic              susp
);
  logic [DATA_W-1:0] mem [16];
  logic [DATA_W-1:0] wval = '0;
  logic [DATA_W-1:0] hold = '0;
  logic [DATA_W-1:0] st;
  logic [ADDR_W-1:0] last_a;
  logic [3:0]        ia;
  logic [1:0]        arm  = 2'd0;
  logic              busy = 1'b0;
  logic              tog  = 1'b0;
  logic              s2   = 1'b0;
  realtime           t_wr = 0.0;
  wire               stb  = !we_n && !ce_n;
  wire               sel  = !ce_n && !oe_n;

  initial
    foreach (mem[i]) mem[i] = '1;

  assign ready_busy_n = !busy;
  assign st = {wval[DATA_W-1:8], ~wval[7], tog, wval[5:3], s2,
               wval[1:0]};

  // decode writes as either strobe style opens
  always @(posedge stb)
  begin
    last_a = addr;
    t_wr = $realtime;
    if (arm == 2'd1)
    begin
      wval = dq_wr;
      ia = addr[3:0];
      arm = 2'd0;
      busy = 1'b1;
      #(PROG_NS);
      mem[ia] = wval;
      busy = 1'b0;
    end
    else if (arm == 2'd2 && dq_wr == 16'h0030)
    begin
      wval = '0;
      arm = 2'd0;
      busy = 1'b1;
      foreach (mem[i]) mem[i] = '0;
      #(ERASE_NS);
      foreach (mem[i]) mem[i] = '1;
      busy = 1'b0;
    end
    else
      arm = (dq_wr == 16'h00a0) ? 2'd1 : (dq_wr == 16'h0080) ? 2'd2 : 2'd0;
  end

  // toggle bit advances on each rise of either enable while busy, bit 2 only inside the suspended sector
  always @(posedge ce_n or posedge oe_n)
  begin
    if (busy)
      tog = ~tog;
    if (susp && addr[ADDR_W-1:12] == SUSP_SEC)
      s2 = ~s2;
  end

  // array data when neither busy nor suspended; released bus shows inverted last value
  always @*
    if (sel)
      hold = (busy || susp) ? st : mem[addr[3:0]];
  assign dq_rd = sel ? hold : ~hold;
endmodule

// ---- dv/fps_host_ctrl_tb.sv ----
// self-checking bench for the flash host controller
`timescale 1ns/10ps
`include "fps_map.svh"
`define CHK(n, e, g) \
  begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %s exp %h got %h", n, (e), (g)); end end

module fps_host_ctrl_tb;
  logic        sys_clk, rst, reg_wr, reg_rd, irq, susp;
  logic        dq_oe, ce_n, oe_n, we_n, hv, rbn;
  logic [4:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rv, seed;
  logic [18:0] fa, a;
  logic [15:0] dq_out, dq_in, pv;
  realtime     t0;
  int          bad_count, compares;

  fps_host_ctrl #(.POLL_MAX(16'h0010)) fps_host_ctrl_inst (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .flash_addr(fa),
    .flash_dq_out(dq_out), .flash_dq_oe(dq_oe), .flash_dq_in(dq_in),
    .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
    .flash_reset_hv(hv), .ready_busy_n(rbn));

  // model delays kept off the clock edges to avoid sampling races
  fps_flash_model #(.PROG_NS(2010), .ERASE_NS(20010)) fps_flash_model_inst (
    .addr(fa), .dq_wr(dq_out), .dq_rd(dq_in), .ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .ready_busy_n(rbn), .susp(susp));

  // free-running 20 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic give_verdict();
    if (bad_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic wr(input logic [4:0] ad, input logic [31:0] d);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    // let an edge pass so a following write never re-assigns the strobe
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [4:0] ad);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
    @(posedge sys_clk);
  endtask

  task automatic settle();
    @(posedge sys_clk);
    #1;
  endtask

  // bounded wait for one status bit
  task automatic wst(input int b, input logic v);
    int n;
    n = 0;
    rv = {32{~v}};
    while (rv[b] !== v && n < 3000)
    begin
      rd(`FPS_OFF_STATUS);
      n++;
    end
    `CHK("wait", v, rv[b])
    if (rv[b] !== v)
      give_verdict();
  endtask

  task automatic go(input logic [2:0] c);
    wr(`FPS_OFF_CTRL, {28'h0, c, 1'b1});
    wst(0, 1'b0);
  endtask

  initial
  begin
    rst <= 1'b1;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= 5'h00;
    reg_wdata <= 32'h0;
    susp <= 1'b0;
    seed = 32'hc50fa780;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd(`FPS_OFF_CFG);
    `CHK("cfg reset", 32'h0, rv)
    rd(5'h1e);
    `CHK("unmapped", 32'h0, rv)
    // program with every strobe and poll style
    for (int i = 0; i < 4; i++)
    begin
      seed = xs(seed);
      a = seed[18:0];
      pv = seed[31:16];
      wr(`FPS_OFF_CFG, {30'h0, i[0] ^ i[1], i[1]});
      wr(`FPS_OFF_WDATA, 32'h00a0);
      go(`FPS_CMD_WRITE);
      wr(`FPS_OFF_WDATA, {16'h0, pv});
      wr(`FPS_OFF_ADDR, {13'h0, a});
      go(i == 3 ? `FPS_CMD_WRITE_LAST : `FPS_CMD_WRITE);
      go(i[0] ? `FPS_CMD_POLL_DATA : `FPS_CMD_POLL_TOG);
      rd(`FPS_OFF_RDATA);
      `CHK("poll data", {16'h0, pv}, rv)
      `CHK("cell", pv, fps_flash_model_inst.mem[a[3:0]])
    end
    // protect and unprotect address pattern
    for (int k = 0; k < 2; k++)
    begin
      wr(`FPS_OFF_CFG, {29'h0, k[0], 2'h0});
      wr(`FPS_OFF_WDATA, 32'h0);
      go(`FPS_CMD_PROTECT);
      `CHK("prot", {k[0], 2'b10}, {fa[6], fa[1:0]})
    end
    // temporary unprotect setup time
    wr(`FPS_OFF_CFG, 32'h8);
    t0 = $realtime;
    rd(`FPS_OFF_STATUS);
    `CHK("wr allowed", 1'b0, rv[2])
    go(`FPS_CMD_WRITE);
    `CHK("setup", 1'b1, fps_flash_model_inst.t_wr - t0 >= 4000.0)
    wr(`FPS_OFF_CFG, 32'h0);
    // sector erase, poll timeout while it runs
    wr(`FPS_OFF_WDATA, 32'h80);
    go(`FPS_CMD_WRITE);
    wr(`FPS_OFF_WDATA, 32'h30);
    go(`FPS_CMD_WRITE);
    `CHK("preprog", 16'h0, fps_flash_model_inst.mem[a[3:0]])
    rd(`FPS_OFF_ISTAT);
    go(`FPS_CMD_POLL_TOG);
    rd(`FPS_OFF_ISTAT);
    `CHK("timeout", 1'b1, rv[`FPS_EV_TIMEOUT])
    wst(1, 1'b1);
    `CHK("erased", 16'hffff, fps_flash_model_inst.mem[a[3:0]])
    // suspend toggle inside and outside the suspended sector
    susp <= 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      wr(`FPS_OFF_ADDR, {13'h0, k[0] ? 7'h06 : 7'h05, 12'h0});
      rd(`FPS_OFF_ISTAT);
      go(`FPS_CMD_POLL_TOG);
      rd(`FPS_OFF_ISTAT);
      `CHK("susp", ~k[0], rv[`FPS_EV_SUSPEND])
    end
    susp <= 1'b0;
    // interrupt masked, unmasked, cleared by read
    wr(`FPS_OFF_IMASK, 32'h0);
    go(`FPS_CMD_READ);
    `CHK("irq masked", 1'b0, irq)
    wr(`FPS_OFF_IMASK, 32'h1);
    settle();
    `CHK("irq", 1'b1, irq)
    rd(`FPS_OFF_ISTAT);
    `CHK("done ev", 1'b1, rv[`FPS_EV_DONE])
    settle();
    `CHK("irq clr", 1'b0, irq)
    give_verdict();
  end
endmodule
